// [design/stwtp_pkg.sv]
// Purpose: Constants and types for the sensor two-wire target port
// Assumes: 250 MHz core clock
// Notes: Times kept in their own units, cycle counts derived here
package stwtp_pkg;
    localparam int CLK_MHZ = 250;
    localparam logic [4:0] TGT_ADDR_HI = 5'h12;
    localparam logic [6:0] GCALL_ADDR = 7'h00;
    localparam logic [6:0] ARA_ADDR = 7'h0c;
    localparam logic [7:0] GCALL_RESET_CMD = 8'h06;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] UNLOCK_REG_INDEX = 8'h04;
    localparam int UNLOCK_BIT_POS = 15;
    localparam int NVM_PROG_MS = 7;
    localparam int TIMEOUT_MS = 35;
    localparam int POR_LOAD_US = 1500;
    // Written as ms * MHz * 1000 or us * MHz so no product leaves 32 bits
    localparam int NVM_PROG_CYCLES = NVM_PROG_MS * CLK_MHZ * 1000;
    localparam int TIMEOUT_CYCLES = TIMEOUT_MS * CLK_MHZ * 1000;
    localparam int POR_LOAD_CYCLES = POR_LOAD_US * CLK_MHZ;
    localparam int SCL_MIN_KHZ = 1;
    localparam int SCL_MAX_KHZ = 400;

    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_ADDR = 8'h02,
        ST_AACK = 8'h04,
        ST_RXB = 8'h08,
        ST_RACK = 8'h10,
        ST_TXB = 8'h20,
        ST_TACK = 8'h40,
        ST_WAIT = 8'h80
    } stwtp_state_e;

    typedef enum logic [1:0] {
        K_REG = 2'h0,
        K_GCALL = 2'h1,
        K_ARA = 2'h2
    } stwtp_kind_e;
endpackage

// [design/stwtp_target.sv]
// Purpose: Two-wire target port with pointer access, alert response and nvm lock
// Assumes: SCL and SDA are oversampled by CLOCK (4 ns) through two flops each
// Notes: Open-drain SDA; SCL is never driven, there is no SCL output at all
`timescale 1ns/10ps
module stwtp_target
    import stwtp_pkg::*;
#(
    parameter int NVM_PROG_CYC = NVM_PROG_CYCLES,
    parameter int TIMEOUT_CYC = TIMEOUT_CYCLES,
    parameter int POR_LOAD_CYC = POR_LOAD_CYCLES
)
(
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RESET,
    // Bus pins
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    // Strap, already resolved to two bits
    input wire logic [1:0] ADDRESS_STRAP_PIN,
    // Register side
    output logic [7:0] REG_ADDR,
    output logic [15:0] REG_WDATA,
    output logic REG_WRITE,
    output logic NVM_WRITE,
    output logic REG_READ,
    input wire logic [15:0] REG_RDATA,
    output logic REG_RELOAD,
    // Alert side
    input wire logic ALERT_ACTIVE,
    input wire logic ALERT_HIGH_CAUSE,
    input wire logic THERM_MODE,
    output logic ALERT_RELEASE,
    // Status
    output logic NVM_BUSY,
    output logic NVM_UNLOCK_BIT,
    output logic POR_LOADING
);
    localparam int CW = 32;

    if (NVM_PROG_CYC < 1 || TIMEOUT_CYC < 1 || POR_LOAD_CYC < 1)
    begin
        $error("stwtp_target: cycle counts must be at least one");
    end

    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic scl_p;
        logic sda_p;
        stwtp_state_e st;
        stwtp_kind_e kind;
        logic [3:0] bitc;
        logic [7:0] sh;
        logic rw;
        logic [1:0] bytec;
        logic [7:0] ptr;
        logic [7:0] hi;
        logic [15:0] txw;
        logic lost;
        logic [3:0] strap_s;
        logic [15:0] wdat;
        logic wr;
        logic nvw;
        logic rd;
        logic reload;
        logic arel;
        logic unl;
        logic [CW-1:0] busy_cnt;
        logic [CW-1:0] por_cnt;
        logic [CW-1:0] to_cnt;
        logic sda_o;
    } stwtp_s;

    stwtp_s s_q, s_d;

    logic scl, sda, scl_rise, scl_fall, start_c, stop_c;
    logic [6:0] my_addr;
    logic [7:0] rx_byte;

    // Conditions seen on the synchronised lines only
    assign scl = s_q.scl_s[1];
    assign sda = s_q.sda_s[1];
    assign scl_rise = scl && !s_q.scl_p;
    assign scl_fall = !scl && s_q.scl_p;
    assign start_c = scl && s_q.scl_p && s_q.sda_p && !sda;
    assign stop_c = scl && s_q.scl_p && !s_q.sda_p && sda;
    assign my_addr = {TGT_ADDR_HI, s_q.strap_s[3:2]};
    assign rx_byte = {s_q.sh[6:0], sda};

    // Next-state logic for the whole port
    always_comb
    begin
        s_d = s_q;
        s_d.scl_s = {s_q.scl_s[0], SCL_IN};
        s_d.sda_s = {s_q.sda_s[0], SDA_IN};
        s_d.strap_s = {s_q.strap_s[1:0], ADDRESS_STRAP_PIN};
        s_d.scl_p = scl;
        s_d.sda_p = sda;
        s_d.wr = 1'b0;
        s_d.nvw = 1'b0;
        s_d.rd = 1'b0;
        s_d.reload = 1'b0;
        s_d.arel = 1'b0;
        // Programming and power-on load timers
        if (s_q.busy_cnt != '0)
            s_d.busy_cnt = s_q.busy_cnt - 1'b1;
        if (s_q.por_cnt != '0)
            s_d.por_cnt = s_q.por_cnt - 1'b1;
        // Stuck-low watchdog; only counts inside a transfer
        if (s_q.st != ST_IDLE && (!scl || (s_q.sda_o && !sda)))
            s_d.to_cnt = s_q.to_cnt + 1'b1;
        else
            s_d.to_cnt = '0;

        case (s_q.st)
            ST_IDLE:
            begin
                s_d.sda_o = 1'b0;
            end
            ST_ADDR, ST_RXB:
            begin
                if (scl_rise)
                begin
                    s_d.sh = rx_byte;
                    s_d.bitc = s_q.bitc + 4'h1;
                end
                if (scl_fall && s_q.bitc == 4'h8)
                begin
                    s_d.bitc = 4'h0;
                    s_d.sda_o = 1'b1;
                    if (s_q.st == ST_ADDR)
                    begin
                        s_d.rw = s_q.sh[0];
                        s_d.bytec = 2'h0;
                        s_d.st = ST_AACK;
                        if (s_q.sh[7:1] == my_addr)
                            s_d.kind = K_REG;
                        else if (s_q.sh == {GCALL_ADDR, 1'b0})
                            s_d.kind = K_GCALL;
                        else if (s_q.sh == {ARA_ADDR, 1'b1} && ALERT_ACTIVE)
                            s_d.kind = K_ARA;
                        else
                        begin
                            s_d.sda_o = 1'b0;
                            s_d.st = ST_WAIT;
                        end
                    end
                    else
                    begin
                        s_d.st = ST_RACK;
                        s_d.bytec = (s_q.bytec == 2'h2) ? 2'h1 : s_q.bytec + 2'h1;
                        if (s_q.kind == K_GCALL)
                        begin
                            if (s_q.sh == GCALL_RESET_CMD)
                                s_d.reload = 1'b1;
                        end
                        else if (s_q.bytec == 2'h0)
                            s_d.ptr = s_q.sh;
                        else if (s_q.bytec == 2'h1)
                            s_d.hi = s_q.sh;
                        else
                        begin
                            s_d.wdat = {s_q.hi, s_q.sh};
                            // Writes are dropped during power-on load
                            if (s_q.por_cnt == '0)
                            begin
                                s_d.wr = 1'b1;
                                s_d.nvw = s_q.unl;
                                if (s_q.unl)
                                    s_d.busy_cnt = CW'(NVM_PROG_CYC);
                                if (s_q.ptr == UNLOCK_REG_INDEX)
                                    s_d.unl = s_q.hi[UNLOCK_BIT_POS - 8];
                            end
                        end
                    end
                end
            end
            ST_AACK, ST_RACK:
            begin
                if (scl_fall)
                begin
                    s_d.sda_o = 1'b0;
                    if (s_q.st == ST_AACK && s_q.rw)
                    begin
                        s_d.st = ST_TXB;
                        s_d.lost = 1'b0;
                        if (s_q.kind == K_ARA)
                            s_d.txw = {my_addr, ALERT_HIGH_CAUSE, 8'hff};
                        else
                        begin
                            s_d.txw = REG_RDATA;
                            s_d.rd = 1'b1;
                        end
                        s_d.sda_o = (s_q.kind == K_ARA) ? !my_addr[6] : !REG_RDATA[15];
                    end
                    else
                        s_d.st = ST_RXB;
                end
            end
            ST_TXB:
            begin
                // Arbitration: a released one that reads low has lost
                if (scl_rise && !s_q.sda_o && !sda && s_q.kind == K_ARA)
                    s_d.lost = 1'b1;
                if (scl_fall)
                begin
                    s_d.bitc = s_q.bitc + 4'h1;
                    s_d.txw = {s_q.txw[14:0], 1'b1};
                    s_d.sda_o = !s_q.txw[14] && !s_q.lost && !(s_q.kind == K_ARA &&
                        !s_q.sda_o && !sda);
                    if (s_q.bitc == 4'h7)
                    begin
                        s_d.bitc = 4'h0;
                        s_d.sda_o = 1'b0;
                        s_d.st = ST_TACK;
                    end
                end
            end
            ST_TACK:
            begin
                if (scl_rise)
                begin
                    if (s_q.kind == K_ARA)
                    begin
                        s_d.arel = !s_q.lost && !THERM_MODE;
                        s_d.st = ST_WAIT;
                    end
                    else if (sda)
                        s_d.st = ST_WAIT;
                end
                if (scl_fall && s_q.st == s_d.st)
                begin
                    s_d.st = ST_TXB;
                    s_d.sda_o = !s_q.txw[15];
                end
            end
            default:
            begin
                s_d.sda_o = 1'b0;
            end
        endcase

        // START from anywhere begins addressing; STOP always idles
        if (start_c)
        begin
            s_d.st = ST_ADDR;
            s_d.bitc = 4'h0;
            s_d.sda_o = 1'b0;
        end
        else if (stop_c || s_q.to_cnt >= CW'(TIMEOUT_CYC))
        begin
            s_d.st = ST_IDLE;
            s_d.sda_o = 1'b0;
        end
        // General-call reset relocks and reruns the power-on load
        if (s_q.reload)
        begin
            s_d.unl = 1'b0;
            s_d.ptr = PTR_RESET;
            s_d.por_cnt = CW'(POR_LOAD_CYC);
        end
    end

    // State register
    always_ff @(posedge CLOCK)
    begin
        if (RESET)
        begin
            s_q <= '0;
            s_q.scl_s <= 2'h3;
            s_q.sda_s <= 2'h3;
            s_q.scl_p <= 1'b1;
            s_q.sda_p <= 1'b1;
            s_q.st <= ST_IDLE;
            s_q.kind <= K_REG;
            s_q.ptr <= PTR_RESET;
            s_q.unl <= 1'b0;
            s_q.por_cnt <= CW'(POR_LOAD_CYC);
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs; SDA only ever pulled low, SCL left alone
    assign SDA_OUT = 1'b0;
    assign SDA_OE = s_q.sda_o;
    assign REG_ADDR = s_q.ptr;
    assign REG_WDATA = s_q.wdat;
    assign REG_WRITE = s_q.wr;
    assign NVM_WRITE = s_q.nvw;
    assign REG_READ = s_q.rd;
    assign REG_RELOAD = s_q.reload;
    assign ALERT_RELEASE = s_q.arel;
    assign NVM_BUSY = (s_q.busy_cnt != '0) || (s_q.por_cnt != '0);
    assign NVM_UNLOCK_BIT = s_q.unl;
    assign POR_LOADING = s_q.por_cnt != '0;
endmodule

// [verif/stwtp_assertions.sv]
// Purpose: Port-level checks for the two-wire target port
// Assumes: Timeout count matches the bound instance
// Notes: Bound to every stwtp_target instance
`timescale 1ns/10ps
module stwtp_assertions
    import stwtp_pkg::*;
#(
    parameter int TIMEOUT_CYC = 200
)
(
    // Clock, reset and bus
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic SCL_IN,
    input wire logic SDA_OE,
    // Register side
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WRITE,
    input wire logic NVM_WRITE,
    input wire logic REG_READ,
    input wire logic REG_RELOAD,
    // Alert and status
    input wire logic THERM_MODE,
    input wire logic ALERT_RELEASE,
    input wire logic NVM_BUSY,
    input wire logic NVM_UNLOCK_BIT,
    input wire logic POR_LOADING
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RESET);
    logic [15:0] low_q;
    // Length of the current SCL low run
    always_ff @(posedge CLOCK)
    begin
        low_q <= (RESET || SCL_IN) ? 16'h0 : low_q + 16'h1;
    end
    // Programming begins with a paired write pulse
    sequence s_prog;
        REG_WRITE && NVM_WRITE;
    endsequence
    a_locked_volatile: assert property (REG_WRITE && !$past(NVM_UNLOCK_BIT) |-> !NVM_WRITE)
        else $error("nvm written while locked");
    a_unlocked_prog: assert property (REG_WRITE && $past(NVM_UNLOCK_BIT) |-> NVM_WRITE)
        else $error("unlocked write skipped nvm");
    a_busy_held: assert property (s_prog |-> ##[1:3] NVM_BUSY [*8])
        else $error("busy flag not held");
    a_reload_relock: assert property (REG_RELOAD |-> ##[0:3] !NVM_UNLOCK_BIT && POR_LOADING)
        else $error("reload left store unlocked");
    a_load_no_write: assert property (POR_LOADING |-> !REG_WRITE)
        else $error("write taken during load");
    a_reset_ptr: assert property ($fell(RESET) |-> REG_ADDR == PTR_RESET && !NVM_UNLOCK_BIT)
        else $error("bad state after reset");
    a_read_ptr_kept: assert property (REG_READ |=> $stable(REG_ADDR))
        else $error("read moved the pointer");
    a_ara_therm: assert property (ALERT_RELEASE |-> !THERM_MODE)
        else $error("alert released in therm mode");
    a_timeout_free: assert property (int'(low_q) > TIMEOUT_CYC + 8 |-> !SDA_OE)
        else $error("SDA held past timeout");
endmodule
bind stwtp_target stwtp_assertions #(.TIMEOUT_CYC(TIMEOUT_CYC)) stwtp_assertions_inst (
    .CLOCK, .RESET, .SCL_IN, .SDA_OE, .REG_ADDR, .REG_WRITE, .NVM_WRITE, .REG_READ,
    .REG_RELOAD, .THERM_MODE, .ALERT_RELEASE, .NVM_BUSY, .NVM_UNLOCK_BIT, .POR_LOADING);

// [verif/stwtp_host_model.sv]
// Purpose: Bus controller model for the two-wire target port
// Assumes: SDA has a pull-up outside; 64 ns SCL period
// Notes: SCL stands high between frames
`timescale 1ns/10ps
module stwtp_host_model
(
    // Bus lines
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    // Idle bus, both lines released
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Start or repeated start; 64 ns period (15.625 MHz) lies far outside the 1 to 400 kHz limits
    task automatic start;
        #16 sda_low = 1'b0;
        #16 scl = 1'b1;
        #16 sda_low = 1'b1;
        #16 scl = 1'b0;
    endtask
    task automatic stop;
        #16 sda_low = 1'b1;
        #16 scl = 1'b1;
        #16 sda_low = 1'b0;
        #16;
    endtask
    // SDA only moves while SCL is low
    task automatic wbit(input logic v);
        #16 sda_low = !v;
        #16 scl = 1'b1;
        #32 scl = 1'b0;
    endtask
    task automatic rbit(output logic v);
        #16 sda_low = 1'b0;
        #16 scl = 1'b1;
        #16 v = sda;
        #16 scl = 1'b0;
    endtask
    // Byte out MSB first, returns the ninth bit (0 = ack)
    task automatic wbyte(input logic [7:0] d, output logic nack);
        for (int i = 7; i >= 0; i--)
            wbit(d[i]);
        rbit(nack);
    endtask
    task automatic rbyte(output logic [7:0] d, input logic nack);
        for (int i = 7; i >= 0; i--)
            rbit(d[i]);
        wbit(nack);
    endtask
endmodule

// [verif/test_sensor_two_wire_target_port.sv]
// Purpose: Self-checking bench for the two-wire target port
// Assumes: Host model drives the bus; register file kept here
// Notes: Short nvm, timeout and load counts
`timescale 1ns/10ps
module test_sensor_two_wire_target_port
    import stwtp_pkg::*;
;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [1:0] strap = 2'h0;
    logic alert = 1'b0;
    logic high = 1'b0;
    logic therm = 1'b0;
    logic scl, sda_low, sda_oe, sda_out, sda, nk, unlock, busy, loading, reg_read;
    logic reg_write, nvm_write, reg_reload, alert_release;
    logic [7:0] reg_addr, b;
    logic [15:0] reg_wdata, w;
    logic [15:0] regs [256];
    logic [15:0] wr_cnt = 16'h0, nv_cnt = 16'h0, rl_cnt = 16'h0, ar_cnt = 16'h0;
    logic [15:0] rp_cnt = 16'h0;
    int cyc = 0;
    int num_errors = 0;
    int total_checks = 0;
    // 250 MHz core clock; open-drain SDA with pull-up
    always #2 clock = ~clock;
    assign sda = !(sda_low || (sda_oe && !sda_out));
    stwtp_host_model host (.scl(scl), .sda_low(sda_low), .sda(sda));
    stwtp_target #(.NVM_PROG_CYC(300), .TIMEOUT_CYC(200), .POR_LOAD_CYC(1000)) stwtp_target_inst (
        .CLOCK(clock), .RESET(reset), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
        .SDA_OE(sda_oe), .ADDRESS_STRAP_PIN(strap), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WRITE(reg_write), .NVM_WRITE(nvm_write), .REG_READ(reg_read),
        .REG_RDATA(regs[reg_addr]), .REG_RELOAD(reg_reload), .ALERT_ACTIVE(alert),
        .ALERT_HIGH_CAUSE(high), .THERM_MODE(therm), .ALERT_RELEASE(alert_release),
        .NVM_BUSY(busy), .NVM_UNLOCK_BIT(unlock), .POR_LOADING(loading));
    // Register file and event tallies; outputs are unknown until reset lands
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (reg_write === 1'b1)
            regs[reg_addr] <= reg_wdata;
        if (!reset)
        begin
            wr_cnt <= wr_cnt + {15'h0, reg_write};
            nv_cnt <= nv_cnt + {15'h0, nvm_write};
            rl_cnt <= rl_cnt + {15'h0, reg_reload};
            ar_cnt <= ar_cnt + {15'h0, alert_release};
            rp_cnt <= rp_cnt + {15'h0, reg_read};
        end
        if (cyc == 30000)
        begin
            num_errors++;
            results();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic adr(input logic [7:0] a, input logic exp_nack);
        host.start();
        host.wbyte(a, nk);
        chk(nk, exp_nack);
    endtask
    // Pointer then word; ack checks skipped while loading
    task automatic wr(input logic [7:0] p, input logic [15:0] d, input bit ck);
        logic [2:0] acks;
        adr({TGT_ADDR_HI, strap, 1'b0}, 1'b0);
        host.wbyte(p, acks[2]);
        host.wbyte(d[15:8], acks[1]);
        host.wbyte(d[7:0], acks[0]);
        host.stop();
        if (ck)
            chk(acks, 3'h0);
    endtask
    task automatic rd(input logic [7:0] p, input bit set_ptr, input logic [15:0] exp);
        if (set_ptr)
        begin
            adr({TGT_ADDR_HI, strap, 1'b0}, 1'b0);
            host.wbyte(p, nk);
            chk(nk, 1'b0);
        end
        adr({TGT_ADDR_HI, strap, 1'b1}, 1'b0);
        host.rbyte(w[15:8], 1'b0);
        host.rbyte(w[7:0], 1'b1);
        host.stop();
        chk(w, exp);
    endtask
    // Host polls the busy flag before any further write
    task automatic wait_idle;
        for (int i = 0; i < 2000 && busy !== 1'b0; i++)
            @(posedge clock);
        // Step off the edge so the next bus change does not race the flops
        #1;
    endtask
    task automatic results;
        if (num_errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        #1;
        chk({unlock, loading, reg_addr}, {1'b0, 1'b1, PTR_RESET});
        wr(8'h02, 16'h1234, 0);
        chk(wr_cnt, 16'h0);
        wait_idle();
        for (int s = 0; s < 4; s++)
        begin
            @(posedge clock) strap <= 2'(s);
            #1;
            adr({TGT_ADDR_HI, ~strap, 1'b0}, 1'b1);
            host.stop();
            // Pointers 5 to 8 keep clear of the unlock register
            wr(8'(s + 5), 16'ha5c0 + 16'(s), 1);
            chk(reg_addr, 8'(s + 5));
            rd(8'(s + 5), 1, 16'ha5c0 + 16'(s));
            rd(8'h00, 0, 16'ha5c0 + 16'(s));
        end
        chk(rp_cnt, 16'h8);
        chk(nv_cnt, 16'h0);
        wr(UNLOCK_REG_INDEX, 16'h8000, 1);
        chk(unlock, 1'b1);
        wait_idle();
        w = nv_cnt;
        wr(8'h05, 16'hbeef, 1);
        chk(nv_cnt, w + 16'h1);
        chk(busy, 1'b1);
        wait_idle();
        adr({GCALL_ADDR, 1'b0}, 1'b0);
        host.wbyte(GCALL_RESET_CMD, nk);
        host.stop();
        chk({nk, unlock, reg_addr, rl_cnt[0]}, {1'b0, 1'b0, PTR_RESET, 1'b1});
        wait_idle();
        for (int c = 0; c < 2; c++)
        begin
            @(posedge clock) alert <= 1'b1;
            high <= c[0];
            therm <= c[0];
            #1;
            adr({ARA_ADDR, 1'b1}, 1'b0);
            host.rbyte(b, 1'b1);
            host.stop();
            chk(b, {TGT_ADDR_HI, strap, c[0]});
            chk(ar_cnt, 16'h1);
        end
        // Lower-addressed rival pulls SDA low; this port loses, alert stays
        @(posedge clock) therm <= 1'b0;
        #1;
        adr({ARA_ADDR, 1'b1}, 1'b0);
        host.wbyte({TGT_ADDR_HI, 2'h0, 1'b0}, nk);
        host.stop();
        chk(ar_cnt, 16'h1);
        b = {TGT_ADDR_HI, strap, 1'b0};
        host.start();
        for (int i = 7; i >= 0; i--)
            host.wbit(b[i]);
        repeat (260) @(posedge clock);
        #1;
        chk(sda_oe, 1'b0);
        host.stop();
        host.wbyte(b, nk);
        chk(nk, 1'b1);
        host.stop();
        results();
    end
endmodule
